// ===== rtl/qot_pkg.sv
// constants and types for the quadrature / one-shot timer channel
// assumes an apb master with 32-bit data and byte addresses
package qot_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] QOT_OFF_CTRL = 8'h00;
   localparam logic [7:0] QOT_OFF_START = 8'h04;
   localparam logic [7:0] QOT_OFF_TIMER = 8'h08;
   localparam logic [7:0] QOT_OFF_STAT = 8'h0c;

   // ****************************************
   // control field positions
   // ****************************************
   localparam int QOT_CB_RUN = 0;
   localparam int QOT_CB_MODE = 1;
   localparam int QOT_CB_FREE = 2;
   localparam int QOT_CB_X4 = 3;
   localparam int QOT_CB_PSL = 4;
   localparam int QOT_CB_TRIG = 6;
   localparam int QOT_CB_PULSE = 7;
   localparam int QOT_CB_OVTRG = 8;
   localparam int QOT_CTRL_W = 9;

   // ****************************************
   // status field positions
   // ****************************************
   localparam int QOT_SB_BUSY = 0;
   localparam int QOT_SB_PIN_A = 1;
   localparam int QOT_SB_PIN_B = 2;

   // ****************************************
   // reset values and counts
   // ****************************************
   localparam logic [8:0] QOT_CTRL_RST = 9'h000;
   localparam logic [15:0] QOT_CNT_RST = 16'h0000;
   localparam logic [15:0] QOT_RLD_RST = 16'h0000;
   localparam logic [15:0] QOT_CNT_MAX = 16'hffff;
   localparam logic [15:0] QOT_CNT_MIN = 16'h0000;
   localparam logic [4:0] QOT_DIV8_LAST = 5'h07;
   localparam logic [4:0] QOT_DIV32_LAST = 5'h1f;

   typedef enum logic [1:0] {QOT_SRC_F1, QOT_SRC_F8, QOT_SRC_F32, QOT_SRC_SUB} qot_src_t;
   typedef enum logic [1:0] {QOT_STEP_NONE, QOT_STEP_UP, QOT_STEP_DOWN} qot_step_t;
   typedef enum logic {QOT_IDLE, QOT_RUN} qot_os_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } qot_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } qot_apb_rsp_t;

   typedef struct packed {
      logic [8:0] ctrl;
      logic [15:0] cnt;
      logic [15:0] rld;
      qot_os_t os;
      logic [4:0] psc;
      logic pin_a;
      logic pin_b;
      logic [31:0] rdata;
      logic slverr;
      logic irq;
   } qot_state_t;

endpackage : qot_pkg

// ===== rtl/qot_timer.sv
// one timer channel: two-phase event counting and retriggerable one-shot
// assumes pins and the subclock tick are synchronous to pclk; apb master
`timescale 1ns/1ps
`default_nettype none

module qot_timer #(
   parameter int CHANNEL = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire qot_pkg::qot_apb_req_t apb_req,
   output var qot_pkg::qot_apb_rsp_t apb_rsp,
   input wire logic timer_a_input_pin,
   input wire logic timer_a_output_pin_in,
   output logic timer_a_output_pin_out,
   output logic timer_a_output_pin_oe,
   input wire logic subclock_div32_source,
   input wire logic overflow_trigger,
   output logic irq_req
);
   import qot_pkg::*;

   // ****************************************
   // helpers
   // ****************************************
   // normal processing: only edges of the input pin count
   function automatic qot_step_t norm_step(
      input logic a_old,
      input logic a_new,
      input logic b_new
   );
      qot_step_t r;
      r = QOT_STEP_NONE;
      if (b_new && !a_old && a_new) begin
         r = QOT_STEP_UP;
      end else if (b_new && a_old && !a_new) begin
         r = QOT_STEP_DOWN;
      end
      return r;
   endfunction : norm_step

   // by-4 processing: gray walk over {b,a}, up order is 10,11,01,00
   function automatic qot_step_t quad_step(
      input logic [1:0] old_ba,
      input logic [1:0] new_ba
   );
      qot_step_t r;
      r = QOT_STEP_NONE;
      unique case ({old_ba, new_ba})
         4'b1011, 4'b1101, 4'b0100, 4'b0010: begin
            r = QOT_STEP_UP;
         end
         4'b1110, 4'b0111, 4'b0001, 4'b1000: begin
            r = QOT_STEP_DOWN;
         end
         default: begin
            r = QOT_STEP_NONE;
         end
      endcase
      return r;
   endfunction : quad_step

   function automatic logic is_mapped(input logic [7:0] a);
      return (a == QOT_OFF_CTRL) || (a == QOT_OFF_START) ||
             (a == QOT_OFF_TIMER) || (a == QOT_OFF_STAT);
   endfunction : is_mapped

   // ****************************************
   // counter arithmetic
   // ****************************************
   // plain sixteen-bit step; wrap handling stays with the caller
   function automatic logic [15:0] cnt_step(
      input logic [15:0] c,
      input qot_step_t d
   );
      logic [15:0] r;
      r = c;
      if (d == QOT_STEP_UP) begin
         r = c + 16'h0001;
      end else if (d == QOT_STEP_DOWN) begin
         r = c - 16'h0001;
      end
      return r;
   endfunction : cnt_step

   // true when one more step in direction d would wrap the counter
   function automatic logic at_limit(
      input logic [15:0] c,
      input qot_step_t d
   );
      return ((d == QOT_STEP_UP) && (c == QOT_CNT_MAX)) ||
             ((d == QOT_STEP_DOWN) && (c == QOT_CNT_MIN));
   endfunction : at_limit

   // subclock tick is taken as already one pclk cycle long
   function automatic logic src_tick(
      input qot_src_t sel,
      input logic [4:0] p,
      input logic sub
   );
      logic r;
      r = 1'b1;
      unique case (sel)
         QOT_SRC_F1: begin
            r = 1'b1;
         end
         QOT_SRC_F8: begin
            r = (p[2:0] == QOT_DIV8_LAST[2:0]);
         end
         QOT_SRC_F32: begin
            r = (p == QOT_DIV32_LAST);
         end
         QOT_SRC_SUB: begin
            r = sub;
         end
      endcase
      return r;
   endfunction : src_tick

   // read mux; unmapped offsets read as zero
   function automatic logic [31:0] read_word(
      input logic [7:0] a,
      input qot_state_t st,
      input logic bsy
   );
      logic [31:0] r;
      r = 32'h0000_0000;
      unique case (a)
         QOT_OFF_CTRL: begin
            r[QOT_CTRL_W-1:0] = st.ctrl;
         end
         QOT_OFF_TIMER: begin
            // live count; in one-shot mode software must ignore it
            r[15:0] = st.cnt;
         end
         QOT_OFF_STAT: begin
            r[QOT_SB_BUSY] = bsy;
            r[QOT_SB_PIN_A] = st.pin_a;
            r[QOT_SB_PIN_B] = st.pin_b;
         end
         default: begin
         end
      endcase
      return r;
   endfunction : read_word

   // ****************************************
   // state
   // ****************************************
   qot_state_t q;
   qot_state_t s;

   logic run_flag;
   logic one_shot;
   logic free_run;
   logic two_phase_ok;
   logic by4;
   logic bus_wr;
   logic bus_setup;
   logic sw_start;
   logic tick;
   logic trig;
   logic busy;
   qot_step_t step;
   qot_src_t src;

   assign run_flag = q.ctrl[QOT_CB_RUN];
   assign one_shot = q.ctrl[QOT_CB_MODE];
   assign free_run = q.ctrl[QOT_CB_FREE];
   assign src = qot_src_t'(q.ctrl[QOT_CB_PSL +: 2]);

   // channels without the second pin never count two-phase
   assign two_phase_ok = (CHANNEL >= 2) && (CHANNEL <= 4);
   assign by4 = (CHANNEL == 4) || ((CHANNEL == 3) && q.ctrl[QOT_CB_X4]);

   assign bus_setup = apb_req.psel && !apb_req.penable;
   assign bus_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && ce;
   assign sw_start = bus_wr && (apb_req.paddr == QOT_OFF_START) && apb_req.pwdata[0];

   // ****************************************
   // direction decode
   // ****************************************
   always_comb begin
      if (by4) begin
         step = quad_step({q.pin_b, q.pin_a},
                          {timer_a_output_pin_in, timer_a_input_pin});
      end else begin
         step = norm_step(q.pin_a, timer_a_input_pin, timer_a_output_pin_in);
      end
   end

   // ****************************************
   // count source for one-shot
   // ****************************************
   assign tick = src_tick(src, q.psc, subclock_div32_source);

   // external trigger on a rising input edge, or an overflow from elsewhere
   assign trig = run_flag && (sw_start ||
                 (q.ctrl[QOT_CB_TRIG] && timer_a_input_pin && !q.pin_a) ||
                 (q.ctrl[QOT_CB_OVTRG] && overflow_trigger));

   assign busy = one_shot ? (q.os == QOT_RUN) : run_flag;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s = q;
      if (ce) begin
         s.irq = 1'b0;
         s.pin_a = timer_a_input_pin;
         s.pin_b = timer_a_output_pin_in;
         s.psc = q.psc + 5'h01;

         if (!one_shot) begin
            s.os = QOT_IDLE;
            // stopping only gates counting; the count is kept
            if (run_flag && two_phase_ok) begin
               if (step == QOT_STEP_UP) begin
                  if (at_limit(q.cnt, step)) begin
                     s.irq = 1'b1;
                     s.cnt = free_run ? QOT_CNT_MIN : q.rld;
                  end else begin
                     s.cnt = cnt_step(q.cnt, step);
                  end
               end else if (step == QOT_STEP_DOWN) begin
                  if (at_limit(q.cnt, step)) begin
                     s.irq = 1'b1;
                     s.cnt = free_run ? QOT_CNT_MAX : q.rld;
                  end else begin
                     s.cnt = cnt_step(q.cnt, step);
                  end
               end
            end
         end else begin
            if (!run_flag) begin
               s.os = QOT_IDLE;
            end else if (trig) begin
               s.cnt = q.rld;
               s.os = QOT_RUN;
            end else if ((q.os == QOT_RUN) && tick) begin
               // zero and one both end here so a set value of 0 cannot hang
               if (q.cnt <= 16'h0001) begin
                  s.irq = 1'b1;
                  s.cnt = q.rld;
                  s.os = QOT_IDLE;
               end else begin
                  s.cnt = cnt_step(q.cnt, QOT_STEP_DOWN);
               end
            end
         end

         // ****************************************
         // register writes
         // ****************************************
         if (bus_wr) begin
            unique case (apb_req.paddr)
               QOT_OFF_CTRL: begin
                  s.ctrl = apb_req.pwdata[QOT_CTRL_W-1:0];
               end
               QOT_OFF_TIMER: begin
                  s.rld = apb_req.pwdata[15:0];
                  if (!busy) begin
                     s.cnt = apb_req.pwdata[15:0];
                  end
               end
               default: begin
               end
            endcase
         end

         // ****************************************
         // read data captured in the setup phase
         // ****************************************
         if (bus_setup) begin
            s.slverr = !is_mapped(apb_req.paddr);
            s.rdata = read_word(apb_req.paddr, q, busy);
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.ctrl <= QOT_CTRL_RST;
         q.cnt <= QOT_CNT_RST;
         q.rld <= QOT_RLD_RST;
         q.os <= QOT_IDLE;
         q.psc <= 5'h00;
         q.pin_a <= 1'b0;
         q.pin_b <= 1'b0;
         q.rdata <= 32'h0000_0000;
         q.slverr <= 1'b0;
         q.irq <= 1'b0;
      end else begin
         q <= s;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // pready follows ce so a frozen block stalls the master instead of dropping
   always_comb begin
      apb_rsp.prdata = q.rdata;
      apb_rsp.pready = ce;
      apb_rsp.pslverr = q.slverr;
   end

   assign irq_req = q.irq;
   assign timer_a_output_pin_out = (q.os == QOT_RUN);
   // in two-phase mode the pin is only ever an input
   assign timer_a_output_pin_oe = one_shot && q.ctrl[QOT_CB_PULSE];

endmodule : qot_timer

`default_nettype wire

// ===== verification/qot_enc_model.sv
// two-phase encoder: one gray step per up or dn command
// assumes commands are one-cycle levels from the bench
`timescale 1ns/1ps
`default_nettype none
module qot_enc_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic up,
   input wire logic dn,
   output logic pin_a,
   output logic pin_b
);
   logic [1:0] ph_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_ff <= 2'h0;
      end else if (up) begin
         ph_ff <= ph_ff + 2'h1;
      end else if (dn) begin
         ph_ff <= ph_ff - 2'h1;
      end
   end
   // pins are inputs to the channel, pin_b only while oe is low; {b,a} up order 10,11,01,00
   assign pin_b = !ph_ff[1];
   assign pin_a = ph_ff[0] ^ ph_ff[1];
endmodule : qot_enc_model
`default_nettype wire

// ===== verification/qot_timer_asserts.sv
// checker: port-level properties of the timer channel
// assumes bind onto qot_timer, single pclk domain
`timescale 1ns/1ps
`default_nettype none
module qot_timer_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire qot_pkg::qot_apb_req_t apb_req,
   input wire qot_pkg::qot_apb_rsp_t apb_rsp,
   input wire logic timer_a_output_pin_out,
   input wire logic timer_a_output_pin_oe,
   input wire logic irq_req
);
   import qot_pkg::*;
   logic setup;
   logic wr;
   logic mapped;
   assign setup = apb_req.psel && !apb_req.penable && ce;
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && ce;
   assign mapped = apb_req.paddr inside {QOT_OFF_CTRL, QOT_OFF_START, QOT_OFF_TIMER, QOT_OFF_STAT};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_ce: assert property (apb_rsp.pready == ce)
      else $error("pready differs from ce");
   a_irq_pulse: assert property (irq_req && ce |=> !irq_req)
      else $error("irq held over one cycle");
   a_bad_addr: assert property (setup && !mapped |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
      else $error("unmapped access not refused");
   a_good_addr: assert property (setup && mapped |=> !apb_rsp.pslverr)
      else $error("mapped access refused");
   a_rdata_hold: assert property (!setup |=> $stable(apb_rsp.prdata))
      else $error("read data moved between setups");
   a_ce_freeze: assert property (!ce |=> $stable(irq_req) && $stable(timer_a_output_pin_out))
      else $error("state moved with ce low");
   a_oe_hold: assert property (!wr |=> $stable(timer_a_output_pin_oe))
      else $error("pin enable moved without write");
   a_os_end: assert property ($rose(irq_req) && timer_a_output_pin_oe
      |-> $fell(timer_a_output_pin_out))
      else $error("one-shot irq without pulse end");
   c_irq: cover property ($rose(irq_req));
   c_pulse: cover property ($fell(timer_a_output_pin_out));
   c_err: cover property (apb_rsp.pslverr);
endmodule : qot_timer_asserts
bind qot_timer qot_timer_asserts u_qot_timer_asserts (.pclk, .presetn, .ce, .apb_req,
   .apb_rsp, .timer_a_output_pin_out, .timer_a_output_pin_oe, .irq_req);
`default_nettype wire

// ===== verification/qot_timer_test.sv
// bench for the timer channel, channel three build
// assumes apb with zero wait states while ce high
`timescale 1ns/1ps
`default_nettype none
module qot_timer_test;
   import qot_pkg::*;
   logic pclk = 0;
   logic presetn = 0;
   logic ce = 1;
   logic up = 0;
   logic dn = 0;
   logic sub = 0;
   logic ovt = 0;
   qot_apb_req_t req = '0;
   qot_apb_rsp_t rsp;
   logic out, oe, irq, err;
   logic [31:0] rd;
   logic pin_a, pin_b;
   int fails = 0;
   int checks = 0;
   int hi = 0;
   int irqs = 0;
   always #12.5 pclk = !pclk;
   always @(posedge pclk) begin
      hi <= hi + int'(out === 1'b1);
      irqs <= irqs + int'(irq === 1'b1);
   end
   qot_timer #(.CHANNEL(3)) u_qot_timer (.pclk, .presetn, .ce, .apb_req(req), .apb_rsp(rsp),
      .timer_a_input_pin(pin_a), .timer_a_output_pin_in(oe ? out : pin_b),
      .timer_a_output_pin_out(out), .timer_a_output_pin_oe(oe),
      .subclock_div32_source(sub), .overflow_trigger(ovt), .irq_req(irq));
   qot_enc_model u_qot_enc_model (.pclk, .presetn, .up, .dn, .pin_a, .pin_b);
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      // no wait limit here: only the watchdog ends a stalled access
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rdc(input string n, input logic [31:0] e);
      apb(QOT_OFF_TIMER, 1'b0, 32'h0);
      cmp(n, e, rd);
   endtask : rdc
   task automatic step(input logic u, input int k);
      repeat (k) begin
         up <= u;
         dn <= !u;
         @(posedge pclk);
      end
      up <= 1'b0;
      dn <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : step
   task automatic pend;
      repeat (2) @(posedge pclk);
      while (out === 1'b1) begin
         @(posedge pclk);
      end
      repeat (2) @(posedge pclk);
   endtask : pend
   task automatic t_regs;
      apb(QOT_OFF_CTRL, 1'b0, 32'h0);
      cmp("ctrl", 32'h0, rd);
      rdc("timer", 32'h0);
      apb(8'h10, 1'b0, 32'h0);
      cmp("slverr", 32'h1, {31'h0, err});
      apb(QOT_OFF_TIMER, 1'b1, 32'hfff0);
      rdc("stopped wr", 32'hfff0);
      $display("test regs done");
   endtask : t_regs
   task automatic t_quad;
      int i;
      apb(QOT_OFF_CTRL, 1'b1, 32'h1);
      cmp("oe", 32'h0, {31'h0, oe});
      apb(QOT_OFF_STAT, 1'b0, 32'h0);
      cmp("stat", 32'h5, rd);
      step(1, 4);
      rdc("up", 32'hfff1);
      step(1, 1);
      step(0, 1);
      rdc("back", 32'hfff1);
      apb(QOT_OFF_TIMER, 1'b1, 32'h5);
      rdc("run wr", 32'hfff1);
      i = irqs;
      step(1, 60);
      rdc("reload", 32'h5);
      cmp("ovf irq", i + 1, irqs);
      apb(QOT_OFF_CTRL, 1'b1, 32'h9);
      i = irqs;
      step(0, 6);
      rdc("x4 down", 32'h5);
      cmp("udf irq", i + 1, irqs);
      step(1, 3);
      rdc("x4 up", 32'h8);
      apb(QOT_OFF_CTRL, 1'b1, 32'h8);
      step(1, 2);
      rdc("stop", 32'h8);
      apb(QOT_OFF_TIMER, 1'b1, 32'hffff);
      apb(QOT_OFF_CTRL, 1'b1, 32'hd);
      step(1, 1);
      rdc("free", 32'h0);
      ce <= 1'b0;
      repeat (4) @(posedge pclk);
      ce <= 1'b1;
      step(0, 1);
      rdc("free dn", 32'hffff);
      $display("test quad done");
   endtask : t_quad
   task automatic t_os;
      int h, i;
      apb(QOT_OFF_CTRL, 1'b1, 32'h0);
      apb(QOT_OFF_TIMER, 1'b1, 32'h5);
      apb(QOT_OFF_CTRL, 1'b1, 32'h1c3);
      cmp("oe", 32'h1, {31'h0, oe});
      for (int s = 0; s < 4; s++) begin
         h = hi;
         i = irqs;
         if (s == 0) apb(QOT_OFF_START, 1'b1, 32'h1);
         else if (s == 1) step(1, 4);
         else if (s == 2) begin
            ovt <= 1'b1;
            @(posedge pclk);
            ovt <= 1'b0;
         end else begin
            apb(QOT_OFF_START, 1'b1, 32'h1);
            apb(QOT_OFF_START, 1'b1, 32'h1);
         end
         pend;
         cmp("os len", h + (s == 3 ? 8 : 5), hi);
         cmp("os irq", i + 1, irqs);
      end
      apb(QOT_OFF_TIMER, 1'b1, 32'h14);
      h = hi;
      i = irqs;
      apb(QOT_OFF_START, 1'b1, 32'h1);
      apb(QOT_OFF_CTRL, 1'b1, 32'h182);
      pend;
      cmp("cut", 32'h1, {31'h0, (hi - h) < 20});
      cmp("cut irq", i, irqs);
      apb(QOT_OFF_CTRL, 1'b1, 32'h193);
      apb(QOT_OFF_TIMER, 1'b1, 32'h2);
      h = hi;
      apb(QOT_OFF_START, 1'b1, 32'h1);
      pend;
      cmp("div8", 32'h1, {31'h0, (hi - h) > 8 && (hi - h) <= 16});
      apb(QOT_OFF_CTRL, 1'b1, 32'ha3);
      apb(QOT_OFF_TIMER, 1'b1, 32'h2);
      h = hi;
      apb(QOT_OFF_START, 1'b1, 32'h1);
      pend;
      cmp("div32", 32'h1, {31'h0, (hi - h) > 32 && (hi - h) <= 64});
      apb(QOT_OFF_CTRL, 1'b1, 32'hb3);
      apb(QOT_OFF_TIMER, 1'b1, 32'h3);
      i = irqs;
      apb(QOT_OFF_START, 1'b1, 32'h1);
      repeat (10) @(posedge pclk);
      cmp("sub wait", 32'h1, {31'h0, out});
      repeat (3) begin
         sub <= 1'b1;
         @(posedge pclk);
         sub <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      cmp("sub end", 32'h0, {31'h0, out});
      cmp("sub irq", i + 1, irqs);
      $display("test oneshot done");
   endtask : t_os
   task automatic end_sim;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_quad;
      t_os;
      end_sim;
   end
   // run needs about 400 cycles
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      end_sim;
   end
endmodule : qot_timer_test
`default_nettype wire
